// [rtl/dma_assist.sv]
// Overview of operation
// - Pace select: peripheral line, timer, or unpaced
// - Request numbers fixed globally, 0 to 39
// - Single-cycle pulses bump saturating per-channel credit
// - Nonzero credit requests; decrement on issue
// - Software leaves serviced peripheral FIFOs alone
// - One channel per peripheral request line
// - Completion raises interrupt unless quiet set
// - Quiet channels interrupt only on null trigger
// - Status per channel; write-one clears bits
// - Two interrupt lines, each with own mask
// - Force register asserts each line for debug
// - Fractional timers, one request per cycle max
// - Four timers, selectable by every channel
// - Sniffer observes selected channel, per-channel enable
// - Sniffer takes one word per clock, no stall
// - CRC-32, CRC-16 both orders, sum, parity
// - Checksum result register writable for seed
// - Invert, reverse, swap affect readout only
// - Clearing enable pauses and keeps state
// - Abort clears count, inactive, no completion interrupt
// - Abort bit high until drained; software polls
// - Debug view of credit, reload count; channel reset
// - All-zero trigger write never starts channel
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module dma_assist (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic [3:0]  issue_grant_i,
  output logic [3:0]       issue_req_o,
  output logic [3:0]       chan_busy_o,
  input  wire logic        fifo_valid_i,
  input  wire logic [1:0]  fifo_chan_i,
  input  wire logic [31:0] fifo_data_i,
  input  wire logic [3:0]  inflight_i,
  output logic             irq0_o,
  output logic             irq1_o,
  dma_pace_if.device       pace
);
  localparam int unsigned NC = dma_assist_pkg::NUM_CHAN;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NC-1:0][31:0] ctrl;
    logic [NC-1:0][15:0] count;
    logic [NC-1:0][15:0] reload;
    logic [NC-1:0][5:0]  credit;
    logic [NC-1:0]       busy;
    logic [NC-1:0]       raw_irq;
    logic [NC-1:0]       mask0;
    logic [NC-1:0]       mask1;
    logic [NC-1:0]       force0;
    logic [NC-1:0]       force1;
    logic [NC-1:0]       abort;
    logic [NC-1:0][3:0]  drain;
    logic [3:0][31:0]    timer_cfg;
    logic [31:0]         cs_ctrl;
    logic [31:0]         cs_acc;
    logic [39:0]         req_s1;
    logic [39:0]         req_s2;
    logic [31:0]         rdata;
    logic                ack;
  } dev_state_t;

  dev_state_t s_reg;
  dev_state_t s_next;
  logic [3:0] tick;

  // ----------------------------------------------------------------
  // Pacing timers
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_timer
      pace_timer u_timer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .num_i  (s_reg.timer_cfg[t][31:16]),
        .den_i  (s_reg.timer_cfg[t][15:0]),
        .tick_o (tick[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checksum step: one whole word per call, so no stall is needed
  // ----------------------------------------------------------------
  function automatic logic [31:0] csum_step(input logic [3:0] mode, input logic [31:0] acc,
                                            input logic [31:0] d);
    logic [31:0] c;
    logic [15:0] h;
    c = acc;
    h = acc[15:0];
    case (mode)
      dma_assist_pkg::CS_CRC32_MSB: begin
        for (int i = 31; i >= 0; i--) begin
          c = (c[31] ^ d[i]) ? ((c << 1) ^ dma_assist_pkg::CRC32_POLY) : (c << 1);
        end
      end
      dma_assist_pkg::CS_CRC32_LSB: begin
        for (int i = 0; i < 32; i++) begin
          c = (c[0] ^ d[i]) ? ((c >> 1) ^ dma_assist_pkg::CRC32_POLY_REV) : (c >> 1);
        end
      end
      dma_assist_pkg::CS_CRC16_MSB: begin
        for (int i = 31; i >= 0; i--) begin
          h = (h[15] ^ d[i]) ? ((h << 1) ^ dma_assist_pkg::CRC16_POLY) : (h << 1);
        end
        c = {16'h0000, h};
      end
      dma_assist_pkg::CS_CRC16_LSB: begin
        for (int i = 0; i < 32; i++) begin
          h = (h[0] ^ d[i]) ? ((h >> 1) ^ dma_assist_pkg::CRC16_POLY_REV) : (h >> 1);
        end
        c = {16'h0000, h};
      end
      dma_assist_pkg::CS_PARITY: c = {31'h00000000, acc[0] ^ (^d)};
      dma_assist_pkg::CS_SUM:    c = 32'(acc + d);
      default:                   c = acc;
    endcase
    return c;
  endfunction : csum_step

  // Presentation only; the accumulator is never rewritten by it.
  function automatic logic [31:0] csum_view(input logic [31:0] ctl, input logic [31:0] acc);
    logic [31:0] v;
    v = acc;
    if (ctl[dma_assist_pkg::CS_REV_BIT]) begin
      for (int i = 0; i < 32; i++) v[i] = acc[31-i];
    end
    if (ctl[dma_assist_pkg::CS_INV_BIT]) v = ~v;
    if (ctl[dma_assist_pkg::CS_SWAP_BIT]) v = {v[7:0], v[15:8], v[23:16], v[31:24]};
    return v;
  endfunction : csum_view

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        wr;
  logic        rd;
  logic [5:0]  psel;
  logic        paced_pulse;
  logic [1:0]  ch;
  logic [1:0]  cs_ch;
  logic [31:0] wmask;
  logic [31:0] wval;

  always_comb begin
    s_next     = s_reg;
    s_next.ack = 1'b0;
    s_next.req_s1 = pace.req_pulse;
    s_next.req_s2 = s_reg.req_s1;
    wr    = cyc_i && stb_i && we_i && !s_reg.ack;
    rd    = cyc_i && stb_i && !we_i && !s_reg.ack;
    ch    = adr_i[5:4];
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wval  = dat_i & wmask;
    psel  = 6'h00;
    paced_pulse = 1'b0;
    cs_ch = s_reg.cs_ctrl[dma_assist_pkg::CS_CH_LSB +: 2];

    for (int c = 0; c < NC; c++) begin
      psel = s_reg.ctrl[c][dma_assist_pkg::CTRL_SEL_LSB +: 6];
      if (psel <= dma_assist_pkg::REQ_LAST) begin
        paced_pulse = s_reg.req_s2[psel];
      end else if (psel >= dma_assist_pkg::SEL_TIMER_BASE && psel != dma_assist_pkg::SEL_UNPACED) begin
        paced_pulse = tick[2'(psel - dma_assist_pkg::SEL_TIMER_BASE)];
      end else begin
        paced_pulse = 1'b0;
      end
      // A paced issue consumes one credit; a same-cycle pulse adds one back.
      if (issue_grant_i[c] && issue_req_o[c]) begin
        s_next.count[c] = 16'(s_reg.count[c] - 16'h0001);
        if (psel != dma_assist_pkg::SEL_UNPACED && !paced_pulse) begin
          s_next.credit[c] = 6'(s_reg.credit[c] - 6'h01);
        end
        if (s_reg.count[c] == 16'h0001) begin
          s_next.busy[c] = 1'b0;
          if (!s_reg.ctrl[c][dma_assist_pkg::CTRL_QUIET_BIT]) s_next.raw_irq[c] = 1'b1;
        end
      end else if (paced_pulse && s_reg.credit[c] != 6'h3f) begin
        s_next.credit[c] = 6'(s_reg.credit[c] + 6'h01);
      end
      if (s_reg.abort[c]) begin
        s_next.drain[c] = (s_reg.drain[c] != 4'h0) ? 4'(s_reg.drain[c] - 4'h1) : 4'h0;
        if (s_reg.drain[c] == 4'h0 && !inflight_i[c]) s_next.abort[c] = 1'b0;
      end
    end

    if (fifo_valid_i && s_reg.cs_ctrl[dma_assist_pkg::CS_EN_BIT]
        && fifo_chan_i == cs_ch && s_reg.ctrl[cs_ch][dma_assist_pkg::CTRL_WATCH_BIT]) begin
      s_next.cs_acc = csum_step(s_reg.cs_ctrl[dma_assist_pkg::CS_MODE_LSB +: 4], s_reg.cs_acc,
                                fifo_data_i);
    end

    if (wr) begin
      s_next.ack = 1'b1;
      if (adr_i < dma_assist_pkg::OFS_RAW_IRQ) begin
        if (adr_i[3:0] == dma_assist_pkg::OFS_CH_CTRL[3:0]) begin
          s_next.ctrl[ch] = (s_reg.ctrl[ch] & ~wmask) | wval;
        end else if (adr_i[3:0] == dma_assist_pkg::OFS_CH_COUNT[3:0]) begin
          s_next.reload[ch] = wval[15:0];
        end else if (adr_i[3:0] == dma_assist_pkg::OFS_CH_TRIG[3:0]) begin
          if (dat_i == 32'h00000000) begin
            if (s_reg.ctrl[ch][dma_assist_pkg::CTRL_QUIET_BIT]) s_next.raw_irq[ch] = 1'b1;
          end else if (!s_reg.busy[ch] && !s_reg.abort[ch]
                       && s_reg.ctrl[ch][dma_assist_pkg::CTRL_EN_BIT] && s_reg.reload[ch] != 16'h0000) begin
            s_next.busy[ch]  = 1'b1;
            s_next.count[ch] = s_reg.reload[ch];
          end
        end else if (dat_i[dma_assist_pkg::DBG_RESET_BIT]) begin
          s_next.busy[ch]   = 1'b0;
          s_next.count[ch]  = 16'h0000;
          s_next.credit[ch] = 6'h00;
        end
      end else if (adr_i == dma_assist_pkg::OFS_STAT0) begin
        // Old bits clear where written as one and set in mask0; a completion in this same cycle survives.
        s_next.raw_irq = (s_reg.raw_irq & ~(dat_i[NC-1:0] & s_reg.mask0))
                         | (s_next.raw_irq & ~s_reg.raw_irq);
      end else if (adr_i == dma_assist_pkg::OFS_STAT1) begin
        s_next.raw_irq = (s_reg.raw_irq & ~(dat_i[NC-1:0] & s_reg.mask1))
                         | (s_next.raw_irq & ~s_reg.raw_irq);
      end else if (adr_i == dma_assist_pkg::OFS_MASK0) begin
        s_next.mask0 = dat_i[NC-1:0];
      end else if (adr_i == dma_assist_pkg::OFS_MASK1) begin
        s_next.mask1 = dat_i[NC-1:0];
      end else if (adr_i == dma_assist_pkg::OFS_FORCE0) begin
        s_next.force0 = dat_i[NC-1:0];
      end else if (adr_i == dma_assist_pkg::OFS_FORCE1) begin
        s_next.force1 = dat_i[NC-1:0];
      end else if (adr_i >= dma_assist_pkg::OFS_TIMER_BASE && adr_i < dma_assist_pkg::OFS_CSUM_CTRL) begin
        s_next.timer_cfg[adr_i[3:2]] = (s_reg.timer_cfg[adr_i[3:2]] & ~wmask) | wval;
      end else if (adr_i == dma_assist_pkg::OFS_CSUM_CTRL) begin
        s_next.cs_ctrl = (s_reg.cs_ctrl & ~wmask) | wval;
      end else if (adr_i == dma_assist_pkg::OFS_CSUM_RES) begin
        s_next.cs_acc = (s_reg.cs_acc & ~wmask) | wval;
      end else if (adr_i == dma_assist_pkg::OFS_ABORT) begin
        for (int c = 0; c < NC; c++) begin
          if (dat_i[c]) begin
            s_next.abort[c] = 1'b1;
            s_next.drain[c] = dma_assist_pkg::ABORT_DRAIN_CYC;
            s_next.busy[c]  = 1'b0;
            s_next.count[c] = 16'h0000;
            s_next.raw_irq[c] = s_reg.raw_irq[c];
          end
        end
      end
    end

    s_next.rdata = 32'h00000000;
    if (rd) begin
      s_next.ack = 1'b1;
      if (adr_i < dma_assist_pkg::OFS_RAW_IRQ) begin
        if (adr_i[3:0] == dma_assist_pkg::OFS_CH_CTRL[3:0]) begin
          s_next.rdata = s_reg.ctrl[ch];
          s_next.rdata[dma_assist_pkg::CTRL_BUSY_BIT] = s_reg.busy[ch];
        end else if (adr_i[3:0] == dma_assist_pkg::OFS_CH_COUNT[3:0]) begin
          s_next.rdata = {16'h0000, s_reg.count[ch]};
        end else if (adr_i[3:0] == dma_assist_pkg::OFS_CH_DEBUG[3:0]) begin
          s_next.rdata = {10'h000, s_reg.credit[ch], s_reg.reload[ch]};
        end
      end else if (adr_i == dma_assist_pkg::OFS_RAW_IRQ) s_next.rdata = 32'(s_reg.raw_irq);
      else if (adr_i == dma_assist_pkg::OFS_MASK0)  s_next.rdata = 32'(s_reg.mask0);
      else if (adr_i == dma_assist_pkg::OFS_MASK1)  s_next.rdata = 32'(s_reg.mask1);
      else if (adr_i == dma_assist_pkg::OFS_FORCE0) s_next.rdata = 32'(s_reg.force0);
      else if (adr_i == dma_assist_pkg::OFS_FORCE1) s_next.rdata = 32'(s_reg.force1);
      else if (adr_i == dma_assist_pkg::OFS_STAT0)  s_next.rdata = 32'((s_reg.raw_irq & s_reg.mask0) | s_reg.force0);
      else if (adr_i == dma_assist_pkg::OFS_STAT1)  s_next.rdata = 32'((s_reg.raw_irq & s_reg.mask1) | s_reg.force1);
      else if (adr_i >= dma_assist_pkg::OFS_TIMER_BASE && adr_i < dma_assist_pkg::OFS_CSUM_CTRL)
        s_next.rdata = s_reg.timer_cfg[adr_i[3:2]];
      else if (adr_i == dma_assist_pkg::OFS_CSUM_CTRL) s_next.rdata = s_reg.cs_ctrl;
      else if (adr_i == dma_assist_pkg::OFS_CSUM_RES)  s_next.rdata = csum_view(s_reg.cs_ctrl, s_reg.cs_acc);
      else if (adr_i == dma_assist_pkg::OFS_ABORT)     s_next.rdata = 32'(s_reg.abort);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      for (int c = 0; c < NC; c++) begin
        s_reg.ctrl[c][dma_assist_pkg::CTRL_SEL_LSB +: 6] <= dma_assist_pkg::CTRL_SEL_RST;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      // Unpaced channels ignore credit and run at full speed.
      issue_req_o[c] = s_reg.busy[c] && s_reg.ctrl[c][dma_assist_pkg::CTRL_EN_BIT]
                       && (s_reg.credit[c] != 6'h00
                           || s_reg.ctrl[c][dma_assist_pkg::CTRL_SEL_LSB +: 6] == dma_assist_pkg::SEL_UNPACED);
    end
  end

  assign chan_busy_o = s_reg.busy;
  assign irq0_o = |((s_reg.raw_irq & s_reg.mask0) | s_reg.force0);
  assign irq1_o = |((s_reg.raw_irq & s_reg.mask1) | s_reg.force1);
  assign dat_o  = s_reg.rdata;
  assign ack_o  = s_reg.ack;
endmodule : dma_assist
`default_nettype wire

// [rtl/dma_assist_pkg.sv]
package dma_assist_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN    = 4;
  localparam int unsigned NUM_REQ     = 40;
  localparam int unsigned NUM_TIMERS  = 4;
  localparam int unsigned CREDIT_W    = 6;
  localparam int unsigned COUNT_W     = 16;
  localparam int unsigned SEL_W       = 6;

  // ----------------------------------------------------------------
  // Request numbering
  // ----------------------------------------------------------------
  localparam logic [5:0] REQ_PIO0_BASE  = 6'h00;
  localparam logic [5:0] REQ_PIO1_BASE  = 6'h08;
  localparam logic [5:0] REQ_SPI_BASE   = 6'h10;
  localparam logic [5:0] REQ_UART_BASE  = 6'h14;
  localparam logic [5:0] REQ_PWM_BASE   = 6'h18;
  localparam logic [5:0] REQ_I2C_BASE   = 6'h20;
  localparam logic [5:0] REQ_ADC        = 6'h24;
  localparam logic [5:0] REQ_XIP_BASE   = 6'h25;
  localparam logic [5:0] REQ_LAST       = 6'h27;
  localparam logic [5:0] SEL_TIMER_BASE = 6'h3b;
  localparam logic [5:0] SEL_UNPACED    = 6'h3f;

  // ----------------------------------------------------------------
  // Register byte offsets (word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CH_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CH_COUNT   = 8'h04;
  localparam logic [7:0] OFS_CH_TRIG    = 8'h08;
  localparam logic [7:0] OFS_CH_DEBUG   = 8'h0c;
  localparam logic [7:0] CH_STRIDE_SH   = 8'h04;
  localparam logic [7:0] OFS_RAW_IRQ    = 8'h40;
  localparam logic [7:0] OFS_MASK0      = 8'h44;
  localparam logic [7:0] OFS_FORCE0     = 8'h48;
  localparam logic [7:0] OFS_STAT0      = 8'h4c;
  localparam logic [7:0] OFS_MASK1      = 8'h50;
  localparam logic [7:0] OFS_FORCE1     = 8'h54;
  localparam logic [7:0] OFS_STAT1      = 8'h58;
  localparam logic [7:0] OFS_TIMER_BASE = 8'h60;
  localparam logic [7:0] OFS_CSUM_CTRL  = 8'h70;
  localparam logic [7:0] OFS_CSUM_RES   = 8'h74;
  localparam logic [7:0] OFS_ABORT      = 8'h78;

  // ----------------------------------------------------------------
  // Channel control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_QUIET_BIT = 1;
  localparam int unsigned CTRL_WATCH_BIT = 2;
  localparam int unsigned CTRL_SEL_LSB   = 8;
  localparam int unsigned CTRL_BUSY_BIT  = 24;
  localparam logic [5:0]  CTRL_SEL_RST   = 6'h3f;
  localparam int unsigned DBG_RESET_BIT  = 31;

  // Checksum control: [0] enable, [2:1] channel, [6:3] mode,
  // [7] bit reverse out, [8] invert out, [9] byte swap out.
  localparam int unsigned CS_EN_BIT   = 0;
  localparam int unsigned CS_CH_LSB   = 1;
  localparam int unsigned CS_MODE_LSB = 3;
  localparam int unsigned CS_REV_BIT  = 7;
  localparam int unsigned CS_INV_BIT  = 8;
  localparam int unsigned CS_SWAP_BIT = 9;

  typedef enum logic [3:0] {
    CS_CRC32_MSB = 4'h0,
    CS_CRC32_LSB = 4'h1,
    CS_CRC16_MSB = 4'h2,
    CS_CRC16_LSB = 4'h3,
    CS_PARITY    = 4'he,
    CS_SUM       = 4'hf
  } csum_mode_t;

  localparam logic [31:0] CRC32_POLY     = 32'h04c11db7;
  localparam logic [31:0] CRC32_POLY_REV = 32'hedb88320;
  localparam logic [15:0] CRC16_POLY     = 16'h1021;
  localparam logic [15:0] CRC16_POLY_REV = 16'h8408;

  // Abort drains for this many cycles to let in-flight beats settle.
  localparam logic [3:0]  ABORT_DRAIN_CYC = 4'h4;

endpackage : dma_assist_pkg

// [rtl/dma_pace_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface dma_pace_if;
  logic [39:0] req_pulse;

  modport device (input  req_pulse);
  modport periph (output req_pulse);
endinterface : dma_pace_if
`default_nettype wire

// [rtl/pace_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module pace_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] num_i,
  input  wire logic [15:0] den_i,
  output logic             tick_o
);
  typedef struct packed {
    logic [16:0] acc;
    logic        tick;
  } pace_state_t;

  pace_state_t s_reg;
  pace_state_t s_next;

  // Accumulator adds X each clock and emits one tick when it reaches Y, so
  // the rate is X/Y requests per cycle and never more than one.
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (num_i != 16'h0000 && den_i != 16'h0000) begin
      if (s_reg.acc + {1'b0, num_i} >= {1'b0, den_i}) begin
        s_next.acc  = 17'(s_reg.acc + {1'b0, num_i} - {1'b0, den_i});
        s_next.tick = 1'b1;
      end else begin
        s_next.acc = 17'(s_reg.acc + {1'b0, num_i});
      end
    end else begin
      s_next.acc = 17'h00000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
endmodule : pace_timer
`default_nettype wire

// [rtl/periph_req_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module periph_req_gen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  req_num_i,
  input  wire logic        req_strobe_i,
  dma_pace_if.periph       pace
);
  typedef struct packed {
    logic [39:0] pulse;
  } gen_state_t;

  gen_state_t s_reg;
  gen_state_t s_next;

  // Each strobe numbered up to REQ_LAST becomes exactly one single-cycle pulse on its line; higher numbers give none.
  always_comb begin
    s_next.pulse = '0;
    if (req_strobe_i && req_num_i <= dma_assist_pkg::REQ_LAST) begin
      s_next.pulse[req_num_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pace.req_pulse = s_reg.pulse;
endmodule : periph_req_gen
`default_nettype wire

// [tb/dma_assist_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module dma_assist_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [39:0] req_pulse,
  input wire logic        req_strobe_i,
  input wire logic [5:0]  req_num_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [3:0]  issue_req_o,
  input wire logic [3:0]  issue_grant_i,
  input wire logic [3:0]  chan_busy_o,
  input wire logic        irq0_o,
  input wire logic        irq1_o
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic iss;
  assign iss = |(issue_req_o & issue_grant_i);

  pulse_map_a: assert property (req_strobe_i |=> req_pulse == (40'h1 << $past(req_num_i)))
    else $error("request pulse on wrong line");
  pulse_quiet_a: assert property (!req_strobe_i |=> req_pulse == 40'h0)
    else $error("request pulse without strobe");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  issue_busy_a: assert property ((issue_req_o & ~chan_busy_o) == 4'h0)
    else $error("issue request from idle channel");
  busy_start_a: assert property (|(chan_busy_o & ~$past(chan_busy_o)) |-> ack_o && we_i)
    else $error("channel started without a bus write");
  // An interrupt line may only rise from a bus write or a recent issue.
  irq0_cause_a: assert property ($rose(irq0_o) |-> ack_o || $past(ack_o) || $past(iss) || $past(iss, 2))
    else $error("irq0 rose without cause");
  irq1_cause_a: assert property ($rose(irq1_o) |-> ack_o || $past(ack_o) || $past(iss) || $past(iss, 2))
    else $error("irq1 rose without cause");

  cover property ($rose(irq0_o));
  cover property (iss);
  cover property ($fell(|chan_busy_o));
endmodule : dma_assist_sva
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        req;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic        ack_o;
  logic [3:0]  issue_grant_i;
  logic [3:0]  issue_req_o;
  logic [3:0]  chan_busy_o;
  logic        fifo_valid_i;
  logic [1:0]  fifo_chan_i;
  logic [31:0] fifo_data_i;
  logic [3:0]  inflight_i;
  logic        irq0_o;
  logic        irq1_o;
  logic [5:0]  req_num_i;
  logic        req_strobe_i;
  int          bad_count;
  int          samples_checked;
  int          tmo = 0;

  dma_pace_if u_dma_pace_if();
  periph_req_gen u_periph_req_gen(.clk_i, .rst_i, .req_num_i, .req_strobe_i, .pace(u_dma_pace_if));
  dma_assist u_dma_assist(.clk_i, .rst_i, .cyc_i(req), .stb_i(req), .we_i, .adr_i, .sel_i(4'hf), .dat_i,
    .dat_o, .ack_o, .issue_grant_i, .issue_req_o, .chan_busy_o, .fifo_valid_i, .fifo_chan_i,
    .fifo_data_i, .inflight_i, .irq0_o, .irq1_o, .pace(u_dma_pace_if));
  dma_assist_sva u_dma_assist_sva(.clk_i, .rst_i, .req_pulse(u_dma_pace_if.req_pulse), .req_strobe_i,
    .req_num_i, .cyc_i(req), .stb_i(req), .we_i, .ack_o, .dat_o, .issue_req_o, .issue_grant_i,
    .chan_busy_o, .irq0_o, .irq1_o);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One classic cycle; the global timeout bounds the wait for ack.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    req <= 1'b0;
  endtask : wb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rchk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("ctrl0", 8'h00, 32'h00003f00);
    rchk("unmapped", 8'hfc, 32'h0);
    $display("reset test done");
  endtask : t_reset

  // Line 4 is interleaved to show that only the selected line counts.
  task automatic t_credit();
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h00, 32'h505);
    // Only channel 0 listens to line 5 and nothing else touches its FIFO.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      req_strobe_i <= 1'b1;
      req_num_i <= (i == 2) ? 6'd4 : 6'd5;
    end
    @(posedge clk_i);
    req_strobe_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rchk("credit", 8'h0c, 32'h00030002);
    $display("credit test done");
  endtask : t_credit

  task automatic t_issue();
    wb(1'b1, 8'h44, 32'h1);
    wb(1'b1, 8'h08, 32'h1);
    #1 chk("issue req", issue_req_o, 4'h1);
    @(posedge clk_i);
    issue_grant_i <= 4'h1;
    repeat (2) @(posedge clk_i);
    issue_grant_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    #1 chk("busy", chan_busy_o, 4'h0);
    chk("irq lines", {irq0_o, irq1_o}, 2'b10);
    rchk("credit left", 8'h0c, 32'h00010002);
    rchk("status0", 8'h4c, 32'h1);
    wb(1'b1, 8'h4c, 32'h1);
    #1 chk("irq0 clear", irq0_o, 1'b0);
    $display("issue test done");
  endtask : t_issue

  task automatic t_quiet();
    wb(1'b1, 8'h50, 32'h2);
    wb(1'b1, 8'h10, 32'h3f03);
    wb(1'b1, 8'h18, 32'h0);
    #1 chk("null trigger", {chan_busy_o[1], irq0_o, irq1_o}, 3'b001);
    wb(1'b1, 8'h58, 32'h2);
    #1 chk("irq1 clear", irq1_o, 1'b0);
    $display("quiet test done");
  endtask : t_quiet

  task automatic t_force();
    wb(1'b1, 8'h48, 32'h1);
    #1 chk("force0", {irq0_o, irq1_o}, 2'b10);
    wb(1'b1, 8'h48, 32'h0);
    wb(1'b1, 8'h54, 32'h1);
    #1 chk("force1", {irq0_o, irq1_o}, 2'b01);
    wb(1'b1, 8'h54, 32'h0);
    $display("force test done");
  endtask : t_force

  // An unpaced channel is aborted mid-run; no completion interrupt follows.
  task automatic t_abort();
    wb(1'b1, 8'h20, 32'h3f01);
    wb(1'b1, 8'h24, 32'h10);
    wb(1'b1, 8'h28, 32'h1);
    #1 chk("abort start", chan_busy_o[2], 1'b1);
    wb(1'b1, 8'h78, 32'h4);
    #1 chk("abort busy", chan_busy_o[2], 1'b0);
    rchk("abort draining", 8'h78, 32'h4);
    repeat (10) @(posedge clk_i);
    rchk("abort done", 8'h78, 32'h0);
    rchk("abort count", 8'h24, 32'h0);
    rchk("abort no irq", 8'h40, 32'h0);
    $display("abort test done");
  endtask : t_abort

  // Sum mode on channel 0; a word of channel 1 must be ignored.
  task automatic t_csum();
    wb(1'b1, 8'h70, 32'h79);
    wb(1'b1, 8'h74, 32'h10);
    @(posedge clk_i);
    fifo_valid_i <= 1'b1;
    fifo_chan_i  <= 2'h0;
    fifo_data_i  <= 32'h5;
    repeat (2) @(posedge clk_i);
    fifo_chan_i  <= 2'h1;
    @(posedge clk_i);
    fifo_valid_i <= 1'b0;
    rchk("csum sum", 8'h74, 32'h1a);
    wb(1'b1, 8'h70, 32'h179);
    rchk("csum invert", 8'h74, 32'hffffffe5);
    $display("checksum test done");
  endtask : t_csum

  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) tmo <= tmo + 1;

  initial begin
    rst_i         <= 1'b1;
    req           <= 1'b0;
    we_i          <= 1'b0;
    adr_i         <= 8'h00;
    dat_i         <= 32'h0;
    issue_grant_i <= 4'h0;
    fifo_valid_i  <= 1'b0;
    fifo_chan_i   <= 2'h0;
    fifo_data_i   <= 32'h0;
    inflight_i    <= 4'h0;
    req_num_i     <= 6'h00;
    req_strobe_i  <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    fork
      begin
        t_reset();
        t_credit();
        t_issue();
        t_quiet();
        t_force();
        t_abort();
        t_csum();
      end
      begin
        wait (tmo >= 20000);
        bad_count++;
        $display("timeout reached");
      end
    join_any
    results();
  end
endmodule : tb
`default_nettype wire
